// ===== logic/pic_map.vh
// Constants for the pmic control port: addresses, fields, timing
`ifndef PIC_MAP_VH
`define PIC_MAP_VH

`define PIC_DEV_WRITE_BYTE   8'h12
`define PIC_DEV_READ_BYTE    8'h13

`define PIC_SUB_REGULATOR    2'h0
`define PIC_SUB_BACKLIGHT    2'h1
`define PIC_SUB_SEL_MSB      1
`define PIC_SUB_SEL_LSB      0

`define PIC_REG_RESET        8'h00

`define PIC_RG_LINREG1_EN    0
`define PIC_RG_LINREG2_EN    1
`define PIC_RG_BURST_LSB     2
`define PIC_RG_SLEW_LO       5
`define PIC_RG_SLEW_HI       6
`define PIC_RG_UNUSED        7

`define PIC_BL_ENABLE        0
`define PIC_BL_RAMP_HI       1
`define PIC_BL_RAMP_LO       2
`define PIC_BL_MODE_LO       3
`define PIC_BL_MODE_HI       4
`define PIC_BL_DIM_LO        5
`define PIC_BL_DIM_HI        6
`define PIC_BL_SLEW_SLOW     7

`define PIC_BYTE_BITS        4'h8
`define PIC_ACK_SLOT         4'h9

`define PIC_CLK_PERIOD_NS    50
`define PIC_SPIKE_NS         50
`define PIC_FILT_CYCLES      ((`PIC_SPIKE_NS + `PIC_CLK_PERIOD_NS - 1) / `PIC_CLK_PERIOD_NS + 1)

`endif

// ===== logic/pic_i2c_port.v
// I2C slave control port with holding and command latches
`timescale 1ns/100ps
`include "pic_map.vh"

module pic_i2c_port (
    input  wire       SYS_CLK_I,
    input  wire       RESET_I,
    input  wire       SCL_I,
    input  wire       SDA_I,
    output wire       SDA_O,
    output wire       SDA_OE_O,
    input  wire       UVLO_I,
    input  wire       POWERDOWN_STATE_A_I,
    input  wire       POWERDOWN_STATE_B_I,
    input  wire [7:0] STATUS_I,
    output wire       LINREG1_ENABLE_O,
    output wire       LINREG2_ENABLE_O,
    output wire       STEPDOWN1_BURST_SEL_O,
    output wire       STEPDOWN2_BURST_SEL_O,
    output wire       STEPDOWN3_BURST_SEL_O,
    output wire       STEPDOWN_SLEW_LO_O,
    output wire       STEPDOWN_SLEW_HI_O,
    output wire       BACKLIGHT_ENABLE_O,
    output wire       RAMP_TIME_LO_O,
    output wire       RAMP_TIME_HI_O,
    output wire       BOOST_MODE_LO_O,
    output wire       BOOST_MODE_HI_O,
    output wire       DIM_CLOCK_LO_O,
    output wire       DIM_CLOCK_HI_O,
    output wire       BACKLIGHT_SLEW_SLOW_O
);

    localparam [5:0] ST_IDLE   = 6'b000001;
    localparam [5:0] ST_ADDR   = 6'b000010;
    localparam [5:0] ST_SUB    = 6'b000100;
    localparam [5:0] ST_DATA   = 6'b001000;
    localparam [5:0] ST_READ   = 6'b010000;
    localparam [5:0] ST_IGNORE = 6'b100000;

    localparam integer FILT_LAST_INT = `PIC_FILT_CYCLES - 1;
    localparam [1:0]   FILT_LAST     = FILT_LAST_INT[1:0];

    wire [1:0] line_raw;
    reg  [1:0] line_meta;
    reg  [1:0] line_sync;
    reg  [1:0] line_filt;
    reg  [1:0] line_prev;
    reg  [2:0] clr_meta;
    reg  [2:0] clr_sync;
    reg  [7:0] status_meta;
    reg  [7:0] status_sync;

    reg  [5:0] state;
    reg  [3:0] bit_cnt;
    reg  [7:0] shift_in;
    reg  [7:0] shift_out;
    reg  [1:0] sub_sel;
    reg        drive_low;
    reg  [7:0] hold_reg;
    reg  [7:0] hold_bl;
    reg  [7:0] cmd_reg;
    reg  [7:0] cmd_bl;

    wire scl_f;
    wire sda_f;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;
    wire clear_all;
    wire [7:0] next_shift_in;

    assign line_raw = {SDA_I, SCL_I};

    always @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            line_meta <= 2'h3;
            line_sync <= 2'h3;
            clr_meta  <= 3'h0;
            clr_sync  <= 3'h0;
            status_meta <= 8'h00;
            status_sync <= 8'h00;
        end else begin
            line_meta <= line_raw;
            line_sync <= line_meta;
            clr_meta  <= {POWERDOWN_STATE_B_I, POWERDOWN_STATE_A_I, UVLO_I};
            clr_sync  <= clr_meta;
            status_meta <= STATUS_I;
            status_sync <= status_meta;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
            reg [1:0] stable_cnt;
            always @(posedge SYS_CLK_I) begin
                if (RESET_I) begin
                    stable_cnt    <= 2'h0;
                    line_filt[gi] <= 1'b1;
                    line_prev[gi] <= 1'b1;
                end else begin
                    line_prev[gi] <= line_filt[gi];
                    if (line_sync[gi] == line_filt[gi]) begin
                        stable_cnt <= 2'h0;
                    end else if (stable_cnt == FILT_LAST) begin
                        stable_cnt    <= 2'h0;
                        line_filt[gi] <= line_sync[gi];
                    end else begin
                        stable_cnt <= stable_cnt + 2'h1;
                    end
                end
            end
        end
    endgenerate

    assign scl_f    = line_filt[0];
    assign sda_f    = line_filt[1];
    assign scl_rise = scl_f & ~line_prev[0];
    assign scl_fall = ~scl_f & line_prev[0];
    // start and stop while clock high
    assign start_det = scl_f & line_prev[0] & ~sda_f & line_prev[1];
    assign stop_det  = scl_f & line_prev[0] & sda_f & ~line_prev[1];

    assign clear_all = RESET_I | (|clr_sync);

    assign next_shift_in = {shift_in[6:0], sda_f};

    assign SDA_O    = 1'b0;
    assign SDA_OE_O = drive_low;

    // Protocol engine
    always @(posedge SYS_CLK_I) begin
        if (clear_all) begin
            state     <= ST_IDLE;
            bit_cnt   <= 4'h0;
            shift_in  <= 8'h00;
            shift_out <= 8'h00;
            sub_sel   <= 2'h0;
            drive_low <= 1'b0;
            hold_reg  <= `PIC_REG_RESET;
            hold_bl   <= `PIC_REG_RESET;
            cmd_reg   <= `PIC_REG_RESET;
            cmd_bl    <= `PIC_REG_RESET;
        end else if (stop_det) begin
            cmd_reg   <= hold_reg;
            cmd_bl    <= hold_bl;
            state     <= ST_IDLE;
            bit_cnt   <= 4'h0;
            drive_low <= 1'b0;
        end else if (start_det) begin
            state     <= ST_ADDR;
            bit_cnt   <= 4'h0;
            drive_low <= 1'b0;
        end else if (scl_rise) begin
            if (bit_cnt < `PIC_BYTE_BITS) begin
                shift_in <= next_shift_in;
            end
            if (bit_cnt < `PIC_ACK_SLOT) begin
                bit_cnt <= bit_cnt + 4'h1;
            end
        end else if (scl_fall) begin
            case (state)
                ST_ADDR: begin
                    if (bit_cnt == `PIC_BYTE_BITS) begin
                        if (shift_in == `PIC_DEV_WRITE_BYTE) begin
                            drive_low <= 1'b1;
                        end else if (shift_in == `PIC_DEV_READ_BYTE) begin
                            drive_low <= 1'b1;
                            shift_out <= status_sync;
                        end else begin
                            state <= ST_IGNORE;
                        end
                    end else if (bit_cnt == `PIC_ACK_SLOT) begin
                        bit_cnt <= 4'h0;
                        if (shift_in == `PIC_DEV_WRITE_BYTE) begin
                            drive_low <= 1'b0;
                            state     <= ST_SUB;
                        end else begin
                            drive_low <= ~shift_out[7];
                            state     <= ST_READ;
                        end
                    end
                end
                ST_SUB: begin
                    if (bit_cnt == `PIC_BYTE_BITS) begin
                        drive_low <= 1'b1;
                    end else if (bit_cnt == `PIC_ACK_SLOT) begin
                        sub_sel   <= shift_in[`PIC_SUB_SEL_MSB:`PIC_SUB_SEL_LSB];
                        drive_low <= 1'b0;
                        bit_cnt   <= 4'h0;
                        state     <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (bit_cnt == `PIC_BYTE_BITS) begin
                        drive_low <= 1'b1;
                    end else if (bit_cnt == `PIC_ACK_SLOT) begin
                        if (sub_sel == `PIC_SUB_REGULATOR) begin
                            hold_reg <= shift_in;
                        end else if (sub_sel == `PIC_SUB_BACKLIGHT) begin
                            hold_bl <= shift_in;
                        end
                        drive_low <= 1'b0;
                        bit_cnt   <= 4'h0;
                        state     <= ST_IGNORE;
                    end
                end
                ST_READ: begin
                    if (bit_cnt < `PIC_BYTE_BITS) begin
                        shift_out <= {shift_out[6:0], 1'b0};
                        drive_low <= ~shift_out[6];
                    end else begin
                        drive_low <= 1'b0;
                        state     <= ST_IGNORE;
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    drive_low <= 1'b0;
                end
                default: begin
                    state     <= ST_IDLE;
                    drive_low <= 1'b0;
                end
            endcase
        end
    end

    assign LINREG1_ENABLE_O      = cmd_reg[`PIC_RG_LINREG1_EN];
    assign LINREG2_ENABLE_O      = cmd_reg[`PIC_RG_LINREG2_EN];
    assign STEPDOWN1_BURST_SEL_O = cmd_reg[`PIC_RG_BURST_LSB];
    assign STEPDOWN2_BURST_SEL_O = cmd_reg[`PIC_RG_BURST_LSB + 1];
    assign STEPDOWN3_BURST_SEL_O = cmd_reg[`PIC_RG_BURST_LSB + 2];
    assign STEPDOWN_SLEW_LO_O    = cmd_reg[`PIC_RG_SLEW_LO];
    assign STEPDOWN_SLEW_HI_O    = cmd_reg[`PIC_RG_SLEW_HI];
    assign BACKLIGHT_ENABLE_O    = cmd_bl[`PIC_BL_ENABLE];
    assign RAMP_TIME_HI_O        = cmd_bl[`PIC_BL_RAMP_HI];
    assign RAMP_TIME_LO_O        = cmd_bl[`PIC_BL_RAMP_LO];
    assign BOOST_MODE_LO_O       = cmd_bl[`PIC_BL_MODE_LO];
    assign BOOST_MODE_HI_O       = cmd_bl[`PIC_BL_MODE_HI];
    assign DIM_CLOCK_LO_O        = cmd_bl[`PIC_BL_DIM_LO];
    assign DIM_CLOCK_HI_O        = cmd_bl[`PIC_BL_DIM_HI];
    assign BACKLIGHT_SLEW_SLOW_O = cmd_bl[`PIC_BL_SLEW_SLOW];

endmodule // pic_i2c_port

// ===== verification/pic_port_properties.sv
// Checker for the pmic control port pins
`timescale 1ns/100ps

module pic_port_properties (
    input wire SYS_CLK_I,
    input wire RESET_I,
    input wire SCL_I,
    input wire SDA_I,
    input wire SDA_O,
    input wire SDA_OE_O,
    input wire UVLO_I,
    input wire POWERDOWN_STATE_A_I,
    input wire POWERDOWN_STATE_B_I,
    input wire LINREG1_ENABLE_O,
    input wire STEPDOWN_SLEW_HI_O,
    input wire BACKLIGHT_ENABLE_O,
    input wire BACKLIGHT_SLEW_SLOW_O
);
    wire [3:0] outs = {LINREG1_ENABLE_O, STEPDOWN_SLEW_HI_O,
                       BACKLIGHT_ENABLE_O, BACKLIGHT_SLEW_SLOW_O};

    default clocking cb @(posedge SYS_CLK_I); endclocking

    sequence s_idle; SCL_I && SDA_I; endsequence
    sequence s_stop; SCL_I && SDA_I && !$past(SDA_I, 8); endsequence

    property p_rst; RESET_I |=> outs == 4'h0 && !SDA_OE_O; endproperty
    property p_uvlo; disable iff (RESET_I) UVLO_I[*5] |-> outs == 4'h0 && !SDA_OE_O; endproperty
    property p_pda; disable iff (RESET_I) POWERDOWN_STATE_A_I[*5] |-> outs == 4'h0; endproperty
    property p_pdb; disable iff (RESET_I) POWERDOWN_STATE_B_I[*5] |-> outs == 4'h0; endproperty
    property p_sdo; disable iff (RESET_I) SDA_O == 1'b0; endproperty
    property p_oe; disable iff (RESET_I) $changed(SDA_OE_O) |-> !$past(SCL_I, 3); endproperty
    property p_idle; disable iff (RESET_I) s_idle [*8] |-> !SDA_OE_O; endproperty
    property p_apply;
        disable iff (RESET_I || UVLO_I || POWERDOWN_STATE_A_I || POWERDOWN_STATE_B_I)
        !$stable(outs) |-> s_stop;
    endproperty

    a_rst: assert property (p_rst) else $error("not cleared by reset");
    a_uvlo: assert property (p_uvlo) else $error("not cleared by undervoltage");
    a_pda: assert property (p_pda) else $error("not cleared by power-down a");
    a_pdb: assert property (p_pdb) else $error("not cleared by power-down b");
    a_sdo: assert property (p_sdo) else $error("data value not low");
    a_oe: assert property (p_oe) else $error("data drive moved in clock high");
    a_idle: assert property (p_idle) else $error("data driven on idle bus");
    a_apply: assert property (p_apply) else $error("outputs moved without stop");
endmodule // pic_port_properties

bind pic_i2c_port pic_port_properties i_pic_port_properties (.*);

// ===== verification/pic_bus_master.sv
// Behavioural bus master for the serial pins
`timescale 1ns/100ps

module pic_bus_master (
    input  wire sda_i,
    output reg  scl_o,
    output reg  sda_pull_o
);
    reg glitch;

    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
        glitch = 1'b0;
    end

    task start;
        begin
            #600 sda_pull_o = 1'b0;
            #600 scl_o = 1'b1;
            #600 sda_pull_o = 1'b1;
            #600 scl_o = 1'b0;
        end
    endtask

    task stop;
        begin
            #600 sda_pull_o = 1'b1;
            #600 scl_o = 1'b1;
            #600 sda_pull_o = 1'b0;
            #1200;
        end
    endtask

    task xfer(input [8:0] tx, output [8:0] rx);
        integer i;
        begin
            for (i = 8; i >= 0; i = i - 1) begin
                #300 scl_o = glitch;
                #30 scl_o = 1'b0;
                #300 sda_pull_o = !tx[i];
                #620 scl_o = 1'b1;
                #1200 rx[i] = sda_i;
                #50 scl_o = 1'b0;
            end
        end
    endtask
endmodule // pic_bus_master

// ===== verification/pic_i2c_port_bench.sv
// Self-checking bench for the pmic control port
`timescale 1ns/100ps

module pic_i2c_port_bench;
    reg        SYS_CLK_I, RESET_I, UVLO_I, POWERDOWN_STATE_A_I, POWERDOWN_STATE_B_I;
    reg  [7:0] STATUS_I;
    wire       SCL_I, SDA_I, SDA_O, SDA_OE_O, pull;
    wire       LINREG1_ENABLE_O, LINREG2_ENABLE_O, STEPDOWN1_BURST_SEL_O;
    wire       STEPDOWN2_BURST_SEL_O, STEPDOWN3_BURST_SEL_O, STEPDOWN_SLEW_LO_O;
    wire       STEPDOWN_SLEW_HI_O, BACKLIGHT_ENABLE_O, RAMP_TIME_LO_O, RAMP_TIME_HI_O;
    wire       BOOST_MODE_LO_O, BOOST_MODE_HI_O, DIM_CLOCK_LO_O, DIM_CLOCK_HI_O;
    wire       BACKLIGHT_SLEW_SLOW_O;
    wire [14:0] outs = {BACKLIGHT_SLEW_SLOW_O, DIM_CLOCK_HI_O, DIM_CLOCK_LO_O,
        BOOST_MODE_HI_O, BOOST_MODE_LO_O, RAMP_TIME_LO_O, RAMP_TIME_HI_O,
        BACKLIGHT_ENABLE_O, STEPDOWN_SLEW_HI_O, STEPDOWN_SLEW_LO_O,
        STEPDOWN3_BURST_SEL_O, STEPDOWN2_BURST_SEL_O, STEPDOWN1_BURST_SEL_O,
        LINREG2_ENABLE_O, LINREG1_ENABLE_O};
    integer    error_cnt = 0, checked = 0, k;
    reg  [8:0] rx;

    // Open-drain wire with pull-up
    assign SDA_I = !(pull || SDA_OE_O);
    pic_i2c_port i_pic_i2c_port (.*);
    pic_bus_master i_pic_bus_master (.sda_i(SDA_I), .scl_o(SCL_I), .sda_pull_o(pull));

    initial begin
        SYS_CLK_I = 1'b0;
        forever #25 SYS_CLK_I = !SYS_CLK_I;
    end

    task chk_out(input [14:0] got, input [14:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("BAD %0t value %h want %h", $time, got, exp);
            end
        end
    endtask

    task chk_bit(input got, input exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("BAD %0t bus bit %b want %b", $time, got, exp);
            end
        end
    endtask

    task wr(input [7:0] b, input ack);
        begin
            i_pic_bus_master.xfer({b, 1'b1}, rx);
            chk_bit(rx[0], !ack);
        end
    endtask

    task frame(input [7:0] sub, input [7:0] dat);
        begin
            i_pic_bus_master.start;
            wr(8'h12, 1'b1);
            wr(sub, 1'b1);
            wr(dat, 1'b1);
        end
    endtask

    task t_write;
        begin
            chk_out(outs, 15'h0000);
            frame(8'h00, 8'h5a);
            wr(8'h77, 1'b0);
            frame(8'h01, 8'h33);
            i_pic_bus_master.start;
            wr(8'h24, 1'b0);
            frame(8'h01, 8'ha5);
            chk_out(outs, 15'h0000);
            i_pic_bus_master.stop;
            chk_out(outs, {8'ha5, 7'h5a});
        end
    endtask

    task t_alias;
        begin
            i_pic_bus_master.glitch = 1'b1;
            frame(8'h04, 8'hbc);
            frame(8'h02, 8'hff);
            frame(8'h05, 8'h52);
            i_pic_bus_master.stop;
            i_pic_bus_master.glitch = 1'b0;
            chk_out(outs, {8'h52, 7'h3c});
        end
    endtask

    task t_read;
        begin
            @(negedge SYS_CLK_I) STATUS_I = 8'h96;
            i_pic_bus_master.start;
            wr(8'h13, 1'b1);
            @(negedge SYS_CLK_I) STATUS_I = 8'h00;
            i_pic_bus_master.xfer(9'h1ff, rx);
            chk_out({7'h00, rx[8:1]}, 15'h0096);
            chk_bit(rx[0], 1'b1);
            frame(8'h01, 8'h81);
            i_pic_bus_master.stop;
            chk_out(outs, {8'h81, 7'h3c});
        end
    endtask

    task t_clear;
        begin
            for (k = 0; k < 3; k = k + 1) begin
                frame(8'h00, 8'h7f);
                i_pic_bus_master.stop;
                chk_out(outs, {((k == 0) ? 8'h81 : 8'h00), 7'h7f});
                @(negedge SYS_CLK_I) {UVLO_I, POWERDOWN_STATE_A_I, POWERDOWN_STATE_B_I} = 3'h1 << k;
                repeat (6) @(negedge SYS_CLK_I);
                {UVLO_I, POWERDOWN_STATE_A_I, POWERDOWN_STATE_B_I} = 3'h0;
                chk_out(outs, 15'h0000);
            end
        end
    endtask

    task final_report;
        begin
            $display("Comparisons %0d, errors %0d", checked, error_cnt);
            if (error_cnt == 0 && checked > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    initial begin
        repeat (60000) @(posedge SYS_CLK_I);
        error_cnt = error_cnt + 1;
        final_report;
    end

    initial begin
        RESET_I = 1'b1;
        {UVLO_I, POWERDOWN_STATE_A_I, POWERDOWN_STATE_B_I} = 3'h0;
        STATUS_I = 8'h00;
        repeat (4) @(negedge SYS_CLK_I);
        RESET_I = 1'b0;
        repeat (10) @(negedge SYS_CLK_I);
        t_write;
        t_alias;
        t_read;
        t_clear;
        final_report;
    end
endmodule // pic_i2c_port_bench
